// ### rtl/autoneg_pkg.sv
package autoneg_pkg;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STAT = 5'h01;
	localparam logic [4:0] ADDR_ADV = 5'h04;
	localparam logic [4:0] ADDR_PARTNER = 5'h05;
	localparam logic [4:0] ADDR_EXP = 5'h06;
	localparam logic [4:0] ADDR_SUMMARY = 5'h10;
	localparam int CTRL_SPEED = 13;
	localparam int CTRL_AN_EN = 12;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_DUPLEX = 8;
	localparam int ABIL_LO = 5;
	localparam int ABIL_HI = 8;
	localparam int WORD_NP = 15;
	localparam int WORD_RF = 13;
	localparam logic [15:0] ADV_RESET_BASE = 16'h0001;
	localparam logic [3:0] STRAP_LOW_ABIL = 4'h5;
	localparam logic [3:0] STRAP_HIGH_ABIL = 4'hF;
	localparam logic [15:0] PD_WORD_100 = 16'h0081;
	localparam logic [15:0] PD_WORD_10 = 16'h0021;
	localparam logic [15:0] STAT_FIXED = 16'h7849;
	localparam int STAT_COMPLETE = 5;
	localparam int STAT_RFAULT = 4;
	localparam int STAT_LINK = 2;
	localparam logic LOCAL_NP_ABLE = 1'b0;
	localparam int CLK_PERIOD_NS = 4;
	localparam int BREAK_LINK_MS = 1500;
	localparam int BREAK_LINK_CYC = BREAK_LINK_MS * 1000000 / CLK_PERIOD_NS;
	typedef enum logic [1:0] {MODE_10H, MODE_10F, MODE_100H, MODE_100F} mode_e;
	typedef enum logic [1:0] {ST_FORCED, ST_BREAK, ST_DETECT, ST_GOOD} an_state_e;
endpackage

// ### rtl/ability_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ability_if;
	import autoneg_pkg::*;
	logic [3:0] local_abil;
	logic [3:0] partner_abil;
	mode_e best;
	logic none;
	modport req (output local_abil, output partner_abil, input best, input none);
	modport res (input local_abil, input partner_abil, output best, output none);
endinterface
`default_nettype wire

// ### rtl/mode_resolver.sv
`timescale 1ns/10ps
`default_nettype none
module mode_resolver
	import autoneg_pkg::*;
(
	ability_if.res abil
);
	logic [3:0] common;
	assign common = abil.local_abil & abil.partner_abil;
	// Highest common bit wins: 100F, 100H, 10F, 10H
	always_comb begin
		abil.none = 1'b0;
		if (common[3]) begin
			abil.best = MODE_100F; // see RQ4
		end else if (common[2]) begin
			abil.best = MODE_100H;
		end else if (common[1]) begin
			abil.best = MODE_10F;
		end else if (common[0]) begin
			abil.best = MODE_10H;
		end else begin
			abil.best = MODE_10H;
			abil.none = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### rtl/strap_capture.sv
`timescale 1ns/10ps
`default_nettype none
module strap_capture (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin,
	output logic strap
);
	logic sync1_reg;
	logic sync2_reg;
	always_ff @(posedge clk) begin
		sync1_reg <= pin;
		sync2_reg <= sync1_reg;
	end
	// Captured only while reset is held; later LED use of the pin is ignored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strap <= sync2_reg; // see RQ20
		end
	end
endmodule
`default_nettype wire

// ### rtl/ethernet_autoneg_control.sv
// What this block does
// RQ1: At reset, strap pin loads advertised abilities bits 8:5.
// RQ2: Control register writes override strap behaviour any time after reset.
// RQ3: During negotiation, send exactly the advertisement register contents.
// RQ4: Resolve 100 full, then 100 half, then 10 full, then 10 half.
// RQ5: Four modes supported; negotiation picks best one partner shares.
// RQ6: Control register enables, disables, restarts; forced speed and duplex bits.
// RQ7: Speed and duplex bits ignored while negotiation enabled.
// RQ8: Status summary register reports resolved speed once link is up.
// RQ9: Basic status ability bits read one, except 100BASE-T4 reads zero.
// RQ10: Basic status shows complete, remote fault, link, preamble suppression.
// RQ11: Advertisement defaults to all abilities with strap high, half duplex ones only with strap low; software may clear bits.
// RQ12: Partner register holds received words, or 0081h/0021h after parallel detect.
// RQ13: Expansion shows detect fault, next-page abilities, page received, partner able.
// RQ14: Both link receivers monitored; single valid link configures that technology.
// RQ15: Parallel detect sets partner bit 5 or 7 with selector 00001.
// RQ16: After parallel detect, partner-able reads zero while complete is set.
// RQ17: Both links good at once sets parallel detect fault; no good link does not.
// RQ18: Restart bit or lost link resumes negotiation.
// RQ19: From forced mode, software clears then sets enable to negotiate.
// RQ20: Strap sampled while reset held, then kept regardless of pin.
`timescale 1ns/10ps
`default_nettype none
module ethernet_autoneg_control
	import autoneg_pkg::*;
#(
	parameter int BREAK_LINK_CYCLES = BREAK_LINK_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic ADVERT_STRAP_PIN,
	input wire logic [4:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	input wire logic PAGE_RX_VALID,
	input wire logic [15:0] PAGE_RX_WORD,
	input wire logic LINK10_OK,
	input wire logic LINK100_OK,
	output logic TX_FLP_EN,
	output logic [15:0] TX_WORD,
	output logic SPEED_100,
	output logic FULL_DUPLEX,
	output logic LINK_UP
);
	logic strap;
	logic speed_reg;
	logic an_en_reg;
	logic duplex_reg;
	logic [15:0] adv_reg;
	logic [15:0] partner_reg;
	logic lp_able_reg;
	logic lp_np_reg;
	logic page_rcvd_reg;
	logic pd_fault_reg;
	logic complete_reg;
	mode_e mode_reg;
	an_state_e state_reg;
	logic [31:0] break_cnt_reg;
	logic wr_ctrl;
	logic restart_req;
	logic rd_exp;
	logic mode_link;
	logic pd_one;
	logic pd_two;
	logic [15:0] ctrl_view;
	logic [15:0] stat_view;
	logic [15:0] exp_view;
	logic [15:0] summary_view;

	ability_if abil ();

	strap_capture u_strap (
		.clk(SYS_CLK),
		.reset_n(RESET_N),
		.pin(ADVERT_STRAP_PIN),
		.strap(strap)
	);

	mode_resolver u_resolver (
		.abil(abil.res)
	);

	assign abil.local_abil = adv_reg[ABIL_HI:ABIL_LO];
	assign abil.partner_abil = PAGE_RX_WORD[ABIL_HI:ABIL_LO];

	assign wr_ctrl = REG_WR && REG_ADDR == ADDR_CTRL;
	// Enable rising from zero also restarts, so forced start needs clear-then-set
	assign restart_req = wr_ctrl && REG_WDATA[CTRL_AN_EN]
		&& (REG_WDATA[CTRL_RESTART] || !an_en_reg); // see RQ18
	assign rd_exp = REG_RD && REG_ADDR == ADDR_EXP;
	assign mode_link = (mode_reg == MODE_100F || mode_reg == MODE_100H) ? LINK100_OK : LINK10_OK;
	assign pd_one = LINK10_OK ^ LINK100_OK; // see RQ14
	assign pd_two = LINK10_OK & LINK100_OK;

	// Control register
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			speed_reg <= 1'b1;
			an_en_reg <= 1'b1;
			duplex_reg <= 1'b0;
		end else if (wr_ctrl) begin
			speed_reg <= REG_WDATA[CTRL_SPEED]; // see RQ2
			an_en_reg <= REG_WDATA[CTRL_AN_EN]; // see RQ6
			duplex_reg <= REG_WDATA[CTRL_DUPLEX];
		end
	end

	// Advertisement: strap picks the reset value, software may narrow it
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			adv_reg <= ADV_RESET_BASE;
			adv_reg[ABIL_HI:ABIL_LO] <= strap ? STRAP_HIGH_ABIL : STRAP_LOW_ABIL; // see RQ1
		end else if (REG_WR && REG_ADDR == ADDR_ADV) begin
			adv_reg <= REG_WDATA; // see RQ11
		end
	end

	// Negotiation sequence
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			state_reg <= ST_BREAK;
			break_cnt_reg <= '0;
			complete_reg <= 1'b0;
			mode_reg <= MODE_10H;
		end else if (wr_ctrl && !REG_WDATA[CTRL_AN_EN]) begin
			state_reg <= ST_FORCED;
			complete_reg <= 1'b0;
		end else if (restart_req) begin
			state_reg <= ST_BREAK; // see RQ18
			break_cnt_reg <= '0;
			complete_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_FORCED: begin
					mode_reg <= mode_e'({speed_reg, duplex_reg}); // see RQ6
				end
				ST_BREAK: begin
					// Silence long enough for the partner to drop its link
					if (break_cnt_reg >= 32'(BREAK_LINK_CYCLES - 1)) begin
						state_reg <= ST_DETECT;
					end else begin
						break_cnt_reg <= break_cnt_reg + 32'd1;
					end
				end
				ST_DETECT: begin
					if (PAGE_RX_VALID) begin
						if (!abil.none) begin
							state_reg <= ST_GOOD;
							complete_reg <= 1'b1;
							mode_reg <= abil.best; // see RQ5
						end
					end else if (pd_one) begin
						state_reg <= ST_GOOD;
						complete_reg <= 1'b1;
						mode_reg <= LINK100_OK ? MODE_100H : MODE_10H; // see RQ14
					end
				end
				ST_GOOD: begin
					if (!mode_link) begin
						state_reg <= ST_DETECT; // see RQ18
						complete_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// Partner words and expansion flags
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			partner_reg <= '0;
			lp_able_reg <= 1'b0;
			lp_np_reg <= 1'b0;
		end else if (state_reg == ST_DETECT && PAGE_RX_VALID) begin
			partner_reg <= PAGE_RX_WORD; // see RQ12
			lp_able_reg <= 1'b1;
			lp_np_reg <= PAGE_RX_WORD[WORD_NP];
		end else if (state_reg == ST_DETECT && pd_one) begin
			partner_reg <= LINK100_OK ? PD_WORD_100 : PD_WORD_10; // see RQ15
			lp_able_reg <= 1'b0; // see RQ16
			lp_np_reg <= 1'b0;
		end
	end

	// Latched flags clear on read; a new event in the same cycle wins
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			page_rcvd_reg <= 1'b0;
			pd_fault_reg <= 1'b0;
		end else begin
			if (state_reg == ST_DETECT && PAGE_RX_VALID) begin
				page_rcvd_reg <= 1'b1;
			end else if (rd_exp) begin
				page_rcvd_reg <= 1'b0;
			end
			if (state_reg == ST_DETECT && !PAGE_RX_VALID && pd_two) begin
				pd_fault_reg <= 1'b1; // see RQ17
			end else if (rd_exp) begin
				pd_fault_reg <= 1'b0;
			end
		end
	end

	// Register views
	always_comb begin
		ctrl_view = '0;
		ctrl_view[CTRL_SPEED] = speed_reg;
		ctrl_view[CTRL_AN_EN] = an_en_reg;
		ctrl_view[CTRL_DUPLEX] = duplex_reg;
		stat_view = STAT_FIXED; // see RQ9
		stat_view[STAT_COMPLETE] = complete_reg; // see RQ10
		stat_view[STAT_RFAULT] = lp_able_reg & partner_reg[WORD_RF];
		stat_view[STAT_LINK] = LINK_UP;
		exp_view = {11'h000, pd_fault_reg, lp_np_reg, LOCAL_NP_ABLE, page_rcvd_reg, lp_able_reg}; // see RQ13
		summary_view = {11'h000, complete_reg, 1'b0, FULL_DUPLEX, !SPEED_100, LINK_UP}; // see RQ8
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				ADDR_CTRL: REG_RDATA <= ctrl_view;
				ADDR_STAT: REG_RDATA <= stat_view;
				ADDR_ADV: REG_RDATA <= adv_reg;
				ADDR_PARTNER: REG_RDATA <= partner_reg;
				ADDR_EXP: REG_RDATA <= exp_view;
				ADDR_SUMMARY: REG_RDATA <= summary_view;
				default: REG_RDATA <= '0;
			endcase
		end
	end

	// Line side outputs
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			TX_FLP_EN <= 1'b0;
			TX_WORD <= '0;
			SPEED_100 <= 1'b0;
			FULL_DUPLEX <= 1'b0;
			LINK_UP <= 1'b0;
		end else begin
			TX_FLP_EN <= state_reg == ST_DETECT;
			TX_WORD <= adv_reg; // see RQ3
			if (state_reg == ST_FORCED) begin
				SPEED_100 <= speed_reg; // see RQ7
				FULL_DUPLEX <= duplex_reg;
				LINK_UP <= speed_reg ? LINK100_OK : LINK10_OK;
			end else begin
				SPEED_100 <= mode_reg[1];
				FULL_DUPLEX <= mode_reg[0];
				LINK_UP <= state_reg == ST_GOOD && mode_link;
			end
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	a_strap_adv_load: assert property ($rose(RESET_N) |-> // see RQ1
		adv_reg[ABIL_HI:ABIL_LO] == ($past(strap) ? STRAP_HIGH_ABIL : STRAP_LOW_ABIL))
		else $error("advertisement not loaded from strap");
	a_flp_sends_adv: assert property (state_reg == ST_DETECT ##1 !wr_ctrl // see RQ3
		|-> TX_FLP_EN && TX_WORD == $past(adv_reg))
		else $error("burst word differs from advertisement");
	a_best_mode: assert property (state_reg == ST_DETECT && PAGE_RX_VALID && !wr_ctrl // see RQ4
		&& adv_reg[ABIL_HI] && PAGE_RX_WORD[ABIL_HI] |=> mode_reg == MODE_100F)
		else $error("full duplex 100 not chosen first");
	a_forced_follow: assert property (state_reg == ST_FORCED && !wr_ctrl ##1 state_reg == ST_FORCED // see RQ7
		|=> SPEED_100 == $past(speed_reg, 2) && FULL_DUPLEX == $past(duplex_reg, 2))
		else $error("forced mode ignores control bits");
	a_pd_word: assert property (state_reg == ST_DETECT && !PAGE_RX_VALID && pd_one && !wr_ctrl // see RQ15
		|=> partner_reg == (LINK100_OK ? PD_WORD_100 : PD_WORD_10) && !lp_able_reg)
		else $error("parallel detect word wrong");
	a_pd_fault_set: assert property (state_reg == ST_DETECT && !PAGE_RX_VALID && pd_two // see RQ17
		|=> pd_fault_reg)
		else $error("parallel detect fault missed");
	a_restart_break: assert property (restart_req |=> state_reg == ST_BREAK // see RQ18
		&& break_cnt_reg == 32'd0 && !complete_reg)
		else $error("restart did not break link");
	a_link_loss: assert property (state_reg == ST_GOOD && !mode_link && !wr_ctrl // see RQ18
		|=> state_reg == ST_DETECT ##1 TX_FLP_EN)
		else $error("lost link did not resume negotiation");
	a_status_fixed: assert property (REG_RD && REG_ADDR == ADDR_STAT // see RQ9
		|=> (REG_RDATA & STAT_FIXED) == STAT_FIXED && !REG_RDATA[15])
		else $error("status ability bits wrong");
	a_partner_capture: assert property (state_reg == ST_DETECT && PAGE_RX_VALID // see RQ12
		|=> partner_reg == $past(PAGE_RX_WORD) && lp_able_reg)
		else $error("partner word not captured");
	a_page_flag: assert property (state_reg == ST_DETECT && PAGE_RX_VALID // see RQ13
		|=> page_rcvd_reg)
		else $error("page received flag not set");
	a_summary_speed: assert property (REG_RD && REG_ADDR == ADDR_SUMMARY // see RQ8
		|=> REG_RDATA[0] == $past(LINK_UP) && REG_RDATA[1] == !$past(SPEED_100))
		else $error("summary speed or link wrong");
	a_strap_hold: assert property ($past(RESET_N) |-> $stable(strap)) // see RQ20
		else $error("strap changed after reset");
	a_forced_entry: assert property (wr_ctrl && !REG_WDATA[CTRL_AN_EN] // see RQ2
		|=> state_reg == ST_FORCED && !complete_reg)
		else $error("control write did not force mode");
	c_negotiated: cover property (state_reg == ST_DETECT && PAGE_RX_VALID ##1 complete_reg);
	c_parallel: cover property (state_reg == ST_DETECT && pd_one ##1 complete_reg && !lp_able_reg);
	c_forced_link: cover property (state_reg == ST_FORCED ##2 LINK_UP);
	c_pd_fault: cover property (pd_fault_reg);
endmodule
`default_nettype wire

// ### bench/link_partner_model.sv
`timescale 1ns/10ps
`default_nettype none
module link_partner_model (
	input wire logic clk,
	input wire logic tx_flp_en,
	input wire logic [15:0] tx_word,
	input wire logic cfg_nego,
	input wire logic [15:0] cfg_word,
	input wire logic [3:0] cfg_delay,
	input wire logic cfg_l10,
	input wire logic cfg_l100,
	output logic page_valid = 1'b0,
	output logic [15:0] page_word = 16'h0000,
	output logic link10 = 1'b0,
	output logic link100 = 1'b0,
	output logic [15:0] heard_word = 16'h0000
);
	logic flp_d = 1'b0;
	logic sent = 1'b0;
	logic [3:0] cnt = 4'h0;
	logic nego_q = 1'b0;
	logic [15:0] word_q = 16'h0000;
	logic [3:0] delay_q = 4'h0;
	logic l10_q = 1'b0;
	logic l100_q = 1'b0;
	// Settings taken on the rising edge, away from the falling edge the bench drives on
	always @(posedge clk) begin
		{nego_q, word_q, delay_q, l10_q, l100_q} <= {cfg_nego, cfg_word, cfg_delay, cfg_l10, cfg_l100};
	end
	always @(negedge clk) begin
		flp_d <= tx_flp_en;
		page_valid <= 1'b0;
		// Word line toggles when idle so a stale value is never mistaken for a page
		page_word <= ~page_word;
		if (tx_flp_en) begin
			heard_word <= tx_word;
		end
		if (tx_flp_en && !flp_d) begin
			cnt <= 4'h0;
			sent <= 1'b0;
		end else if (tx_flp_en && !sent && nego_q) begin
			cnt <= cnt + 4'h1;
			if (cnt == delay_q) begin
				page_valid <= 1'b1;
				page_word <= word_q;
				sent <= 1'b1;
			end
		end
		// A negotiating partner brings its link up only after its page went out
		link10 <= l10_q && (sent || !nego_q);
		link100 <= l100_q && (sent || !nego_q);
	end
endmodule
`default_nettype wire

// ### bench/ethernet_autoneg_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ethernet_autoneg_control_tb_top
	import autoneg_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic strap = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic page_valid, link10, link100, flp, spd, fdx, lup;
	logic [15:0] page_word, txw, heard;
	logic cfg_nego = 1'b0;
	logic [15:0] cfg_word = 16'h0000;
	logic [3:0] cfg_delay = 4'h0;
	logic cfg_l10 = 1'b0;
	logic cfg_l100 = 1'b0;
	int err_total = 0;
	int tests_run = 0;
	logic [33:0] neg_tab [5] = '{{16'h01E1, 16'h21E1, 2'b11}, {16'h01E1, 16'h80E1, 2'b10},
		{16'h01E1, 16'h0061, 2'b01}, {16'h01E1, 16'h0021, 2'b00}, {16'h0061, 16'h01E1, 2'b01}};
	logic [15:0] pd_tab [2] = '{16'h0021, 16'h0081};

	always #2 clk = ~clk;

	ethernet_autoneg_control #(.BREAK_LINK_CYCLES(10)) dut_u (.SYS_CLK(clk), .RESET_N(rst_n),
		.ADVERT_STRAP_PIN(strap), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .PAGE_RX_VALID(page_valid), .PAGE_RX_WORD(page_word), .LINK10_OK(link10),
		.LINK100_OK(link100), .TX_FLP_EN(flp), .TX_WORD(txw), .SPEED_100(spd), .FULL_DUPLEX(fdx),
		.LINK_UP(lup));

	link_partner_model partner_u (.clk(clk), .tx_flp_en(flp), .tx_word(txw), .cfg_nego(cfg_nego),
		.cfg_word(cfg_word), .cfg_delay(cfg_delay), .cfg_l10(cfg_l10), .cfg_l100(cfg_l100),
		.page_valid(page_valid), .page_word(page_word), .link10(link10), .link100(link100),
		.heard_word(heard));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask

	// Read data is registered, so it is sampled a full cycle after the strobe
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] mask, input logic [15:0] exp);
		addr = a;
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
		tick(1);
		chk(rdata & mask, exp);
	endtask

	task automatic wait_for(input logic sel, input logic want);
		int i;
		i = 0;
		while (((sel ? lup : flp) !== want) && i < 100) begin
			tick(1);
			i++;
		end
		if (i == 100) begin
			err_total++;
			$display("wrong value at %0t got %h exp %h", $time, !want, want);
			stop_test();
		end
	endtask

	task automatic do_reset(input logic s);
		rst_n = 1'b0;
		strap = s;
		tick(6);
		rst_n = 1'b1;
		tick(1);
	endtask

	initial begin
		logic [15:0] adv, pw;
		logic sp, du;
		tick(1);
		do_reset(1'b0);
		rd_chk(ADDR_ADV, 16'hFFFF, 16'h00A1);
		do_reset(1'b1);
		rd_chk(ADDR_ADV, 16'hFFFF, 16'h01E1);
		strap = 1'b0;
		tick(4);
		rd_chk(ADDR_ADV, 16'hFFFF, 16'h01E1);
		rd_chk(ADDR_CTRL, 16'hFFFF, 16'h3000);
		rd_chk(ADDR_STAT, 16'hFFFF, 16'h7849);
		rd_chk(5'h1F, 16'hFFFF, 16'h0000);
		wait_for(1'b0, 1'b1);
		tick(2);
		chk(heard, 16'h01E1);
		for (int i = 0; i < 5; i++) begin
			{adv, pw, sp, du} = neg_tab[i];
			wr_reg(ADDR_ADV, adv);
			tick(1);
			// Speed bit written as 0 while negotiating; outcome must not follow it
			wr_reg(ADDR_CTRL, 16'h1200);
			cfg_word = pw;
			cfg_delay = 4'(i * 3);
			cfg_nego = 1'b1;
			cfg_l100 = sp;
			cfg_l10 = !sp;
			tick(1);
			chk({15'h0000, flp}, 16'h0000);
			wait_for(1'b0, 1'b1);
			tick(2);
			chk(heard, adv);
			wait_for(1'b1, 1'b1);
			chk({14'h0000, spd, fdx}, {14'h0000, sp, du});
			rd_chk(ADDR_PARTNER, 16'hFFFF, pw);
			rd_chk(ADDR_SUMMARY, 16'h0017, {11'h000, 2'b10, du, !sp, 1'b1});
			rd_chk(ADDR_STAT, 16'hFFFF, 16'h786D | {11'h000, pw[13], 4'h0});
			rd_chk(ADDR_EXP, 16'h000F, {12'h000, pw[15], 3'b011});
			rd_chk(ADDR_EXP, 16'h0002, 16'h0000);
			cfg_nego = 1'b0;
			cfg_l10 = 1'b0;
			cfg_l100 = 1'b0;
			wait_for(1'b1, 1'b0);
			wait_for(1'b0, 1'b1);
		end
		for (int i = 0; i < 2; i++) begin
			wr_reg(ADDR_CTRL, 16'h1200);
			cfg_l10 = (i == 0);
			cfg_l100 = (i == 1);
			wait_for(1'b1, 1'b1);
			chk({14'h0000, spd, fdx}, {14'h0000, cfg_l100, 1'b0});
			rd_chk(ADDR_PARTNER, 16'hFFFF, pd_tab[i]);
			rd_chk(ADDR_EXP, 16'h0001, 16'h0000);
			rd_chk(ADDR_STAT, 16'h0020, 16'h0020);
			cfg_l10 = 1'b0;
			cfg_l100 = 1'b0;
			wait_for(1'b1, 1'b0);
			wait_for(1'b0, 1'b1);
		end
		cfg_l10 = 1'b1;
		cfg_l100 = 1'b1;
		tick(3);
		chk({15'h0000, lup}, 16'h0000);
		rd_chk(ADDR_EXP, 16'h0010, 16'h0010);
		wr_reg(ADDR_CTRL, 16'h0100);
		cfg_l100 = 1'b0;
		tick(3);
		chk({13'h0000, flp, spd, fdx}, 16'h0001);
		wr_reg(ADDR_CTRL, 16'h2000);
		cfg_l10 = 1'b0;
		cfg_l100 = 1'b1;
		tick(3);
		chk({13'h0000, flp, spd, fdx}, 16'h0002);
		cfg_l100 = 1'b0;
		tick(2);
		wr_reg(ADDR_CTRL, 16'h1000);
		wait_for(1'b0, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
